//--- shared/bbc_defines.vh
// Register offsets, field positions and reset values of the received-bit counter
`ifndef RBC_DEFINES_VH
`define RBC_DEFINES_VH

`define RBC_ADDR_W          8
`define RBC_OFF_SNAP0       8'h40
`define RBC_OFF_SNAP1       8'h41
`define RBC_OFF_SNAP2       8'h42
`define RBC_OFF_SNAP3       8'h43
`define RBC_OFF_CONTROL     8'h50
`define RBC_OFF_STATUS      8'h51
`define RBC_OFF_MASK        8'h52
`define RBC_CTL_LATCH_BIT   0
`define RBC_ST_OVF_BIT      0
`define RBC_ST_LOCK_BIT     1
`define RBC_ST_RUN_BIT      2
`define RBC_RST_BYTE        8'h00
`define RBC_RST_COUNT       32'h00000000
`define RBC_MAX_COUNT       32'hffffffff

`endif

//--- src/bbc_bit_counter.v
// Received-bit counter with snapshot registers, overflow flag and interrupt
//
// Contract
// - Latch-counts toggle copies the running count into the snapshot registers.
// - A 32-bit counter advances once per received data bit.
// - Counting starts only when the checker reports lock.
// - Once started, counting continues even after lock is lost.
// - The counter saturates at its maximum and never wraps.
// - Reaching saturation sets the overflow flag in the tester status.
// - The same toggle that captures also clears the counter to zero.
// - Locked at the toggle: counting resumes from zero at once.
// - Unlocked at the toggle: counter holds zero until lock returns.
// - Snapshot spans four bytes, bits 7:0 lowest address, 31:24 highest.
//
// Design decision made here: the address-and-strobe port.
`timescale 1ns/1ps
`include "bbc_defines.vh"

module rbc_bit_counter
#(
	parameter [31:0] COUNT_MAX = `RBC_MAX_COUNT
)
(
	input  wire        clk_sys,
	input  wire        reset,
	input  wire [7:0]  reg_addr,
	input  wire [7:0]  reg_wdata,
	input  wire        reg_wr,
	input  wire        reg_rd,
	output reg  [7:0]  reg_rdata,
	input  wire        rx_lock,
	input  wire        rx_bit_valid,
	output reg         irq
);

	// ------------------------------------------------------------
	// Counter states
	// ------------------------------------------------------------
	// Waiting holds the count at zero until the checker locks
	localparam [1:0] ST_WAIT = 2'b01;
	localparam [1:0] ST_RUN  = 2'b10;

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	function hit;
		input [7:0] addr;
		input [7:0] target;
		begin
			hit = (addr == target);
		end
	endfunction

	function [7:0] pick_byte;
		input [31:0] word;
		input [1:0]  sel;
		begin
			case (sel)
			2'h0:    pick_byte = word[7:0];
			2'h1:    pick_byte = word[15:8];
			2'h2:    pick_byte = word[23:16];
			default: pick_byte = word[31:24];
			endcase
		end
	endfunction

	// Saturating step: at the limit the value stays put, never wraps
	function [31:0] sat_inc;
		input [31:0] value;
		input [31:0] limit;
		begin
			if (value >= limit)
				sat_inc = limit;
			else
				sat_inc = value + 32'h00000001;
		end
	endfunction

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	reg  [1:0]  state;
	reg  [1:0]  next_state;
	reg  [31:0] bit_count;
	reg  [31:0] next_bit_count;
	reg  [7:0]  bit_count_snapshot_byte0;
	reg  [7:0]  bit_count_snapshot_byte1;
	reg  [7:0]  bit_count_snapshot_byte2;
	reg  [7:0]  bit_count_snapshot_byte3;
	reg  [7:0]  next_bit_count_snapshot_byte0;
	reg  [7:0]  next_bit_count_snapshot_byte1;
	reg  [7:0]  next_bit_count_snapshot_byte2;
	reg  [7:0]  next_bit_count_snapshot_byte3;
	reg         latch_counts;
	reg         next_latch_counts;
	reg         latch_counts_seen;
	reg         bit_count_overflow;
	reg         next_bit_count_overflow;
	reg         ovf_mask;
	reg         next_ovf_mask;
	reg  [7:0]  next_reg_rdata;
	reg         lock_meta;
	reg         lock_sync;
	reg         valid_meta;
	reg         valid_sync;

	wire        counting;
	wire        wr_ctl;
	wire        wr_status;
	wire        wr_mask;
	wire        latch_event;
	wire        bit_step;
	wire        sat_hit;
	wire        ovf_clear;

	assign counting    = (state == ST_RUN);
	assign wr_ctl      = reg_wr && hit(reg_addr, `RBC_OFF_CONTROL);
	assign wr_status   = reg_wr && hit(reg_addr, `RBC_OFF_STATUS);
	assign wr_mask     = reg_wr && hit(reg_addr, `RBC_OFF_MASK);
	assign latch_event = latch_counts != latch_counts_seen;
	assign bit_step    = valid_sync && (counting || lock_sync);
	assign sat_hit     = bit_step && (bit_count == COUNT_MAX - 32'h00000001);
	assign ovf_clear   = wr_status && reg_wdata[`RBC_ST_OVF_BIT];

	// ------------------------------------------------------------
	// Input synchronisers
	// ------------------------------------------------------------
	// Lock and bit strobe come from the receive path, treated as foreign
	always @(posedge clk_sys)
	begin
		if (reset)
		begin
			lock_meta <= 1'b0;
			lock_sync <= 1'b0;
		end
		else
		begin
			lock_meta <= rx_lock;
			lock_sync <= lock_meta;
		end
	end

	always @(posedge clk_sys)
	begin
		if (reset)
		begin
			valid_meta <= 1'b0;
			valid_sync <= 1'b0;
		end
		else
		begin
			valid_meta <= rx_bit_valid;
			valid_sync <= valid_meta;
		end
	end

	// ------------------------------------------------------------
	// Latch toggle detection
	// ------------------------------------------------------------
	// Both start at zero, so no false event follows reset
	always @(posedge clk_sys)
	begin
		if (reset)
			latch_counts_seen <= 1'b0;
		else
			latch_counts_seen <= latch_counts;
	end

	// ------------------------------------------------------------
	// Start and hold of counting
	// ------------------------------------------------------------
	always @*
	begin
		next_state = state;
		case (state)
		ST_WAIT:
		begin
			if (lock_sync)
				next_state = ST_RUN;
		end
		ST_RUN:
		begin
			// Lock loss alone never stops a running count
			if (latch_event && !lock_sync)
				next_state = ST_WAIT;
		end
		default:
			next_state = ST_WAIT;
		endcase
	end

	// ------------------------------------------------------------
	// Counter
	// ------------------------------------------------------------
	always @*
	begin
		next_bit_count = bit_count;
		if (latch_event)
			// Bit arriving in the toggle cycle is dropped, not carried
			next_bit_count = `RBC_RST_COUNT;
		else if (bit_step)
			next_bit_count = sat_inc(bit_count, COUNT_MAX);
	end

	always @(posedge clk_sys)
	begin
		if (reset)
		begin
			state     <= ST_WAIT;
			bit_count <= `RBC_RST_COUNT;
		end
		else
		begin
			state     <= next_state;
			bit_count <= next_bit_count;
		end
	end

	// ------------------------------------------------------------
	// Snapshot bytes
	// ------------------------------------------------------------
	always @*
	begin
		next_bit_count_snapshot_byte0 = bit_count_snapshot_byte0;
		next_bit_count_snapshot_byte1 = bit_count_snapshot_byte1;
		next_bit_count_snapshot_byte2 = bit_count_snapshot_byte2;
		next_bit_count_snapshot_byte3 = bit_count_snapshot_byte3;
		if (latch_event)
		begin
			next_bit_count_snapshot_byte0 = pick_byte(bit_count, 2'h0);
			next_bit_count_snapshot_byte1 = pick_byte(bit_count, 2'h1);
			next_bit_count_snapshot_byte2 = pick_byte(bit_count, 2'h2);
			next_bit_count_snapshot_byte3 = pick_byte(bit_count, 2'h3);
		end
	end

	always @(posedge clk_sys)
	begin
		if (reset)
		begin
			bit_count_snapshot_byte0 <= `RBC_RST_BYTE;
			bit_count_snapshot_byte1 <= `RBC_RST_BYTE;
			bit_count_snapshot_byte2 <= `RBC_RST_BYTE;
			bit_count_snapshot_byte3 <= `RBC_RST_BYTE;
		end
		else
		begin
			bit_count_snapshot_byte0 <= next_bit_count_snapshot_byte0;
			bit_count_snapshot_byte1 <= next_bit_count_snapshot_byte1;
			bit_count_snapshot_byte2 <= next_bit_count_snapshot_byte2;
			bit_count_snapshot_byte3 <= next_bit_count_snapshot_byte3;
		end
	end

	// ------------------------------------------------------------
	// Overflow flag
	// ------------------------------------------------------------
	always @*
	begin
		next_bit_count_overflow = bit_count_overflow;
		// Set wins over a write-one clear in the same cycle
		if (sat_hit && !latch_event)
			next_bit_count_overflow = 1'b1;
		else if (ovf_clear)
			next_bit_count_overflow = 1'b0;
	end

	always @(posedge clk_sys)
	begin
		if (reset)
			bit_count_overflow <= 1'b0;
		else
			bit_count_overflow <= next_bit_count_overflow;
	end

	// ------------------------------------------------------------
	// Control and mask registers
	// ------------------------------------------------------------
	always @*
	begin
		next_latch_counts = latch_counts;
		next_ovf_mask     = ovf_mask;
		if (wr_ctl)
			next_latch_counts = reg_wdata[`RBC_CTL_LATCH_BIT];
		if (wr_mask)
			next_ovf_mask = reg_wdata[`RBC_ST_OVF_BIT];
	end

	always @(posedge clk_sys)
	begin
		if (reset)
		begin
			latch_counts <= 1'b0;
			ovf_mask     <= 1'b0;
		end
		else
		begin
			latch_counts <= next_latch_counts;
			ovf_mask     <= next_ovf_mask;
		end
	end

	// ------------------------------------------------------------
	// Read port
	// ------------------------------------------------------------
	// Idle cycles return zero, so several ports can be ORed together
	always @*
	begin
		next_reg_rdata = `RBC_RST_BYTE;
		if (reg_rd)
		begin
			case (reg_addr)
			`RBC_OFF_SNAP0: next_reg_rdata = bit_count_snapshot_byte0;
			`RBC_OFF_SNAP1: next_reg_rdata = bit_count_snapshot_byte1;
			`RBC_OFF_SNAP2: next_reg_rdata = bit_count_snapshot_byte2;
			`RBC_OFF_SNAP3: next_reg_rdata = bit_count_snapshot_byte3;
			`RBC_OFF_CONTROL: next_reg_rdata = {7'h00, latch_counts};
			`RBC_OFF_STATUS: next_reg_rdata = {5'h00, counting, lock_sync, bit_count_overflow};
			`RBC_OFF_MASK: next_reg_rdata = {7'h00, ovf_mask};
			default: next_reg_rdata = `RBC_RST_BYTE;
			endcase
		end
	end

	always @(posedge clk_sys)
	begin
		if (reset)
			reg_rdata <= `RBC_RST_BYTE;
		else
			reg_rdata <= next_reg_rdata;
	end

	// ------------------------------------------------------------
	// Interrupt
	// ------------------------------------------------------------
	// Registered so the pin comes from a flip-flop, one cycle behind the flag
	always @(posedge clk_sys)
	begin
		if (reset)
			irq <= 1'b0;
		else
			irq <= bit_count_overflow && ovf_mask;
	end

endmodule

//--- test/bbc_chk_assertions.sv
// Port checker of the bit counter
`timescale 1ns/1ps
module rbc_chk
(
	input wire       clk_sys,
	input wire       reset,
	input wire [7:0] reg_addr,
	input wire [7:0] reg_wdata,
	input wire       reg_wr,
	input wire       reg_rd,
	input wire [7:0] reg_rdata,
	input wire       rx_lock,
	input wire       rx_bit_valid,
	input wire       irq
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (reset);
	property p_idle; !reg_rd |=> !reg_rdata; endproperty
	a_idle: assert property (p_idle) else $error("idle");
	property p_unmap; reg_rd && reg_addr > 8'h52 |=> !reg_rdata; endproperty
	a_unmap: assert property (p_unmap) else $error("unmapped");
	property p_irq0; $past(reset) |-> !irq; endproperty
	a_irq0: assert property (p_irq0) else $error("irq");
	property p_mask0; reg_wr && reg_addr == 8'h52 && !reg_wdata[0] |=> ##1 !irq; endproperty
	a_mask0: assert property (p_mask0) else $error("mask");
	property p_ctl; reg_wr && reg_addr == 8'h50 ##2 reg_rd && reg_addr == 8'h50
		|=> reg_rdata[0] == $past(reg_wdata[0], 3); endproperty
	a_ctl: assert property (p_ctl) else $error("control");
	property p_mrb; reg_wr && reg_addr == 8'h52 ##2 reg_rd && reg_addr == 8'h52
		|=> reg_rdata[0] == $past(reg_wdata[0], 3); endproperty
	a_mrb: assert property (p_mrb) else $error("mask read");
	property p_lk; rx_lock[*4] ##0 reg_rd && reg_addr == 8'h51 |=> reg_rdata[1]; endproperty
	a_lk: assert property (p_lk) else $error("lock");
	property p_nlk; !rx_lock[*4] ##0 reg_rd && reg_addr == 8'h51 |=> !reg_rdata[1]; endproperty
	a_nlk: assert property (p_nlk) else $error("no lock");
	cover property (reg_wr && reg_addr == 8'h50);
	cover property (reg_rd && reg_addr == 8'h43);
	cover property (rx_lock && rx_bit_valid);
	cover property (irq);
endmodule
bind rbc_bit_counter rbc_chk u_chk (.clk_sys, .reset, .reg_addr, .reg_wdata, .reg_wr,
	.reg_rd, .reg_rdata, .rx_lock, .rx_bit_valid, .irq);

//--- test/testbench.sv
// Bench of the bit counter
`timescale 1ns/1ps
module testbench;
	reg clk_sys = 0, reset = 1, reg_wr = 0, reg_rd = 0, rx_lock = 0, rx_bit_valid = 0;
	reg latch_level = 0;
	reg [7:0] reg_addr = 0, reg_wdata = 0;
	wire [7:0] reg_rdata;
	wire irq;
	logic [7:0] exp_q[$];
	int errors = 0, cmp_count = 0, nb;
	logic rd_d = 0, v;
	always #50 clk_sys = ~clk_sys;
	// Small limit so saturation is reachable in a short run
	rbc_bit_counter #(.COUNT_MAX(32'h000000ff)) u_rbc_bit_counter (.clk_sys, .reset,
		.reg_addr, .reg_wdata, .reg_wr,
		.reg_rd, .reg_rdata, .rx_lock, .rx_bit_valid, .irq);
	task cmp(input logic [7:0] g, e);
		cmp_count++;
		if (g !== e)
		begin
			errors++;
			$display("wrong value at %0t: %h %h", $time, g, e);
		end
	endtask
	task cmp_irq(input logic e);
		@(posedge clk_sys);
		@(negedge clk_sys);
		cmp({7'h00, irq}, {7'h00, e});
	endtask
	task finish_test;
		$display("compares %0d errors %0d", cmp_count, errors);
		if (errors == 0 && cmp_count > 0 && exp_q.size() == 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	always @(posedge clk_sys)
	begin
		if (rd_d) cmp(reg_rdata, exp_q.pop_front());
		rd_d <= reg_rd;
	end
	task wr(input [7:0] a, d);
		@(posedge clk_sys);
		{reg_addr, reg_wdata, reg_wr} <= {a, d, 1'b1};
		@(posedge clk_sys);
		reg_wr <= 0;
	endtask
	task rd(input [7:0] a, e);
		@(posedge clk_sys);
		{reg_addr, reg_rd} <= {a, 1'b1};
		exp_q.push_back(e);
		@(posedge clk_sys);
		reg_rd <= 0;
	endtask
	task rd32(input [31:0] e);
		for (int i = 0; i < 4; i++) rd(8'h40 + 8'(i), e[8*i +: 8]);
	endtask
	task feed(input int n);
		repeat (n)
		begin
			@(posedge clk_sys);
			v = 1'($urandom);
			rx_bit_valid <= v;
			nb += v;
		end
		@(posedge clk_sys);
		rx_bit_valid <= 0;
		repeat (5) @(posedge clk_sys);
	endtask
	task tog; // Either edge latches
		latch_level = ~latch_level;
		wr(8'h50, {7'h00, latch_level});
		rd(8'h50, {7'h00, latch_level});
		repeat (3) @(posedge clk_sys);
	endtask
	initial
	begin
		void'($urandom(92));
		repeat (4) @(posedge clk_sys);
		reset <= 0;
		rd32(32'h0);
		wr(8'h40, 8'hff);
		rd(8'h40, 8'h00);
		rd(8'h60, 8'h00);
		$display("register test done");
		rx_lock <= 1;
		repeat (4) @(posedge clk_sys);
		tog;
		nb = 0;
		feed(40);
		rx_lock <= 0;
		feed(40);
		tog;
		rd32(nb);
		feed(30); // Unlocked bits must be lost
		rd(8'h51, 8'h00);
		rx_lock <= 1;
		repeat (4) @(posedge clk_sys);
		nb = 0;
		feed(30);
		tog;
		rd32(nb);
		nb = 0;
		feed(20);
		tog;
		rd32(nb);
		rd(8'h51, 8'h06);
		wr(8'h52, 8'h01);
		rd(8'h52, 8'h01);
		wr(8'h51, 8'h01);
		wr(8'h52, 8'h00);
		rd(8'h52, 8'h00);
		$display("count test done");
		wr(8'h52, 8'h01);
		tog;
		nb = 0;
		feed(700);
		cmp_irq(1'b1);
		rd(8'h51, 8'h07);
		tog;
		rd32(32'h000000ff);
		wr(8'h51, 8'h01);
		cmp_irq(1'b0);
		rd(8'h51, 8'h06);
		$display("saturation test done");
		repeat (3) @(posedge clk_sys);
		finish_test;
	end
endmodule
